/* core/dag_pkg.sv */
// Shared constants and carrier types for the data address generator.
// Assumes one clock, a core decoder driving the request struct and an APB master.
// What this block does
// - Three pointer pairs, high and low bytes, each holding a 12-bit address.
// - Plain virtual operand accesses the address held in its pointer pair.
// - Indirect accesses ignore bank select and access-bank bit.
// - Post-decrement uses current pointer, then lowers it by one.
// - Post-increment uses current pointer, then raises it by one.
// - Pre-increment raises pointer by one, then uses the new value.
// - Plus-working adds signed working byte to pointer; nothing is modified.
// - Plain virtual operand leaves the pointer pair unchanged.
// - Steps act on the whole 12 bits, carrying between bytes.
// - Pointer steps never touch arithmetic status flags.
// - Indirect target that is a virtual operand reads zero, ignores writes.
// - Indirect write into the pair's own pointer registers stores value without auto step.
// - Pointer registers are real registers reachable by direct operations.
// - Extended set leaves pairs 0 and 1 and the map unchanged.
// - Extended set: literal offset only when access bit 0 and file <= 5Fh.
// - Literal offset target is file field plus pointer pair 2.
// - Access bit 1 or file >= 60h keeps normal addressing.
// - Extended, access bit 0, file >= 60h maps to F60h..FFFh.
// - Access bit 1 selects one of 16 banks by bank select value.
// - Inherent and literal instructions are unaffected by extended set.
// - Access bit 1 joins bank select and file field into 12 bits.
// - Destination bit 1 writes back to source, 0 to working register.
// - Only access addresses 00h..5Fh are remapped to the pointer 2 window.
`default_nettype none

package dag_pkg;
    localparam int ADDR_W = 12;
    localparam int PAIRS = 3;
    // Address map of virtual operands and pointer bytes, per pair
    localparam logic [11:0] VIRT_TOP = 12'hfef;
    localparam logic [11:0] PAIR_STRIDE = 12'h008;
    localparam logic [11:0] OFS_PLAIN = 12'h000;
    localparam logic [11:0] OFS_POST_INC = 12'h001;
    localparam logic [11:0] OFS_POST_DEC = 12'h002;
    localparam logic [11:0] OFS_PRE_INC = 12'h003;
    localparam logic [11:0] OFS_PLUS_WREG = 12'h004;
    localparam logic [11:0] OFS_HIGH = 12'h005;
    localparam logic [11:0] OFS_LOW = 12'h006;
    localparam logic [11:0] PLAIN_OPERAND_1 = 12'hfe7;
    // Access bank split and forced-access bank
    localparam logic [7:0] LIT_MAX = 8'h5f;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    // APB register byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_LAST_ADDR = 8'h04;
    localparam logic [7:0] REG_POINTER0 = 8'h08;
    localparam logic [7:0] REG_POINTER1 = 8'h0c;
    localparam logic [7:0] REG_POINTER2 = 8'h10;
    localparam logic [11:0] POINTER_RESET = 12'h000;
    localparam logic [1:0] CFG_SETTLE = 2'h2;

    typedef enum logic [1:0] {DAG_NONE, DAG_FILE, DAG_FULL} dag_kind_t;
    typedef enum {DAG_OP_PLAIN, DAG_OP_POST_INC, DAG_OP_POST_DEC, DAG_OP_PRE_INC,
                  DAG_OP_PLUS_WREG, DAG_OP_HIGH, DAG_OP_LOW, DAG_OP_NONE} dag_op_t;

    typedef struct packed {
        logic valid;
        dag_kind_t kind;
        logic acc;
        logic dest;
        logic write;
        logic [7:0] file;
        logic [11:0] full;
        logic [7:0] wdata;
        logic [7:0] wreg;
        logic [7:0] bank;
    } dag_req_t;

    typedef struct packed {
        logic en;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } dag_mem_t;

    typedef struct packed {
        logic valid;
        logic to_wreg;
        logic local_data;
        logic null_access;
        logic [7:0] rdata;
        logic [11:0] addr;
    } dag_resp_t;
endpackage : dag_pkg

`default_nettype wire

/* core/dag_core.sv */
// Data address generator: operand resolution, pointer pairs, APB view.
// Assumes the decoder presents one request per cycle and the RAM takes
// the registered memory strobe one cycle later; APB on the same clock.
//
// The APB slave port was decided locally.
`default_nettype none

module dag_core (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ext_enable_pin,
    input wire dag_pkg::dag_req_t req,
    output dag_pkg::dag_mem_t mem,
    output dag_pkg::dag_resp_t resp,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import dag_pkg::*;

    logic [11:0] ptr [PAIRS];
    logic ext_meta, ext_sync, ext_cfg, cfg_done;
    logic [1:0] cfg_cnt;
    logic [11:0] last_addr;
    logic last_indirect, last_null;

    // Decode a 12-bit address into a virtual operand or pointer byte
    function automatic dag_op_t op_of(input logic [11:0] a, output logic [1:0] pair);
        logic [11:0] d;
        op_of = DAG_OP_NONE;
        pair = 2'd0;
        for (int n = 0; n < PAIRS; n++) begin
            d = VIRT_TOP - 12'(n) * PAIR_STRIDE - a;
            if (d <= OFS_LOW) begin
                pair = 2'(n);
                case (d)
                    OFS_PLAIN: op_of = DAG_OP_PLAIN;
                    OFS_POST_INC: op_of = DAG_OP_POST_INC;
                    OFS_POST_DEC: op_of = DAG_OP_POST_DEC;
                    OFS_PRE_INC: op_of = DAG_OP_PRE_INC;
                    OFS_PLUS_WREG: op_of = DAG_OP_PLUS_WREG;
                    OFS_HIGH: op_of = DAG_OP_HIGH;
                    default: op_of = DAG_OP_LOW;
                endcase
            end
        end
    endfunction : op_of

    // Extended enable: synchronise, then freeze once after reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end else begin
            ext_meta <= ext_enable_pin;
            ext_sync <= ext_meta;
        end
    end

    // Held for the whole run so addressing never shifts mid-program
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_cnt <= 2'h0;
            cfg_done <= 1'b0;
            ext_cfg <= 1'b0;
        end else if (!cfg_done) begin
            if (cfg_cnt == CFG_SETTLE) begin
                ext_cfg <= ext_sync;
                cfg_done <= 1'b1;
            end else begin
                cfg_cnt <= cfg_cnt + 2'h1;
            end
        end
    end

    // Stage 1: the address the instruction names directly
    logic [11:0] dir_addr;
    logic dir_valid;
    always_comb begin
        dir_valid = req.valid && (req.kind != DAG_NONE);
        dir_addr = req.full;
        if (req.kind == DAG_FILE) begin
            if (req.acc) begin
                dir_addr = {req.bank[3:0], req.file};
            end else if (ext_cfg && req.file <= LIT_MAX) begin
                dir_addr = ptr[2] + {4'h0, req.file};
            end else if (req.file > LIT_MAX) begin
                dir_addr = {ACCESS_HI_BANK, req.file};
            end else begin
                dir_addr = {ACCESS_LO_BANK, req.file};
            end
        end
    end

    // Stage 2: indirection through a pointer pair, bank ignored
    dag_op_t vop, top;
    logic [1:0] vpair, tpair;
    logic vhit;
    logic [11:0] eff_addr;
    logic [11:0] step_val;
    logic step_en;
    always_comb begin
        vop = op_of(dir_addr, vpair);
        vhit = dir_valid && (vop inside {DAG_OP_PLAIN, DAG_OP_POST_INC, DAG_OP_POST_DEC,
                                         DAG_OP_PRE_INC, DAG_OP_PLUS_WREG});
        eff_addr = dir_addr;
        step_val = ptr[vpair];
        step_en = 1'b0;
        if (vhit) begin
            case (vop)
                DAG_OP_PLAIN: eff_addr = ptr[vpair];
                DAG_OP_POST_INC: begin
                    eff_addr = ptr[vpair];
                    step_val = ptr[vpair] + 12'h001;
                    step_en = 1'b1;
                end
                DAG_OP_POST_DEC: begin
                    eff_addr = ptr[vpair];
                    step_val = ptr[vpair] - 12'h001;
                    step_en = 1'b1;
                end
                DAG_OP_PRE_INC: begin
                    eff_addr = ptr[vpair] + 12'h001;
                    step_val = eff_addr;
                    step_en = 1'b1;
                end
                DAG_OP_PLUS_WREG: eff_addr = ptr[vpair] + {{4{req.wreg[7]}}, req.wreg};
                default: eff_addr = dir_addr;
            endcase
        end
        top = op_of(eff_addr, tpair);
    end

    // Classify the final target
    logic tgt_virt, tgt_ptr, ptr_wr;
    always_comb begin
        tgt_virt = vhit && (top inside {DAG_OP_PLAIN, DAG_OP_POST_INC, DAG_OP_POST_DEC,
                                        DAG_OP_PRE_INC, DAG_OP_PLUS_WREG});
        tgt_ptr = dir_valid && (top inside {DAG_OP_HIGH, DAG_OP_LOW});
        ptr_wr = tgt_ptr && req.write && !tgt_virt;
    end

    // APB write strobe
    logic apb_wr;
    logic [1:0] apb_pair;
    logic apb_pair_hit;
    always_comb begin
        apb_wr = psel && penable && pwrite;
        apb_pair_hit = 1'b1;
        case (paddr)
            REG_POINTER0: apb_pair = 2'd0;
            REG_POINTER1: apb_pair = 2'd1;
            REG_POINTER2: apb_pair = 2'd2;
            default: begin
                apb_pair = 2'd0;
                apb_pair_hit = 1'b0;
            end
        endcase
    end

    // Pointer pairs; a stored write beats the auto step, core beats APB
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int n = 0; n < PAIRS; n++) begin
                ptr[n] <= POINTER_RESET;
            end
        end else begin
            for (int n = 0; n < PAIRS; n++) begin
                if (ptr_wr && tpair == 2'(n)) begin
                    if (top == DAG_OP_HIGH) begin
                        ptr[n][11:8] <= req.wdata[3:0];
                    end else begin
                        ptr[n][7:0] <= req.wdata;
                    end
                end else if (step_en && vpair == 2'(n)) begin
                    ptr[n] <= step_val;
                end else if (apb_wr && apb_pair_hit && apb_pair == 2'(n)) begin
                    ptr[n] <= pwdata[11:0];
                end
            end
        end
    end

    // Memory strobe toward the RAM; nothing issued for local or null targets
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem <= '0;
        end else begin
            mem.en <= dir_valid && !tgt_virt && !tgt_ptr;
            mem.we <= dir_valid && req.write && !tgt_virt && !tgt_ptr;
            mem.addr <= eff_addr;
            mem.wdata <= req.wdata;
        end
    end

    // Answer to the decoder, one cycle after the request
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resp <= '0;
        end else begin
            resp.valid <= dir_valid;
            resp.to_wreg <= !req.dest;
            resp.local_data <= tgt_virt || tgt_ptr;
            resp.null_access <= tgt_virt;
            resp.addr <= eff_addr;
            if (tgt_virt) begin
                resp.rdata <= 8'h00;
            end else if (top == DAG_OP_HIGH) begin
                resp.rdata <= {4'h0, ptr[tpair][11:8]};
            end else if (top == DAG_OP_LOW) begin
                resp.rdata <= ptr[tpair][7:0];
            end else begin
                resp.rdata <= 8'h00;
            end
        end
    end

    // Status kept for software
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_addr <= 12'h000;
            last_indirect <= 1'b0;
            last_null <= 1'b0;
        end else if (dir_valid) begin
            last_addr <= eff_addr;
            last_indirect <= vhit;
            last_null <= tgt_virt;
        end
    end

    // APB slave: zero wait, read data captured in the setup cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= !(apb_pair_hit || paddr == REG_STATUS || paddr == REG_LAST_ADDR);
                case (paddr)
                    REG_STATUS: prdata <= {28'h0, last_null, last_indirect, cfg_done, ext_cfg};
                    REG_LAST_ADDR: prdata <= {20'h0, last_addr};
                    REG_POINTER0: prdata <= {20'h0, ptr[0]};
                    REG_POINTER1: prdata <= {20'h0, ptr[1]};
                    REG_POINTER2: prdata <= {20'h0, ptr[2]};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks on the resolution paths
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_bank_direct: assert property (
        req.valid && req.kind == DAG_FILE && req.acc |-> dir_addr == {req.bank[3:0], req.file})
        else $error("bank direct address wrong");

    a_literal_offset: assert property (
        req.valid && req.kind == DAG_FILE && !req.acc && ext_cfg && req.file <= LIT_MAX
        |-> dir_addr == ptr[2] + {4'h0, req.file})
        else $error("literal offset address wrong");

    a_forced_access: assert property (
        req.valid && req.kind == DAG_FILE && !req.acc && req.file > LIT_MAX
        |-> dir_addr[11:8] == ACCESS_HI_BANK)
        else $error("forced access not in top bank");

    a_post_inc_step: assert property (
        vhit && vop == DAG_OP_POST_INC && !ptr_wr
        |=> ptr[$past(vpair)] == $past(ptr[vpair]) + 12'h001 && resp.addr == $past(ptr[vpair]))
        else $error("post increment wrong");

    a_post_dec_step: assert property (
        vhit && vop == DAG_OP_POST_DEC && !ptr_wr
        |=> ptr[$past(vpair)] == $past(ptr[vpair]) - 12'h001)
        else $error("post decrement wrong");

    a_pre_inc_addr: assert property (
        vhit && vop == DAG_OP_PRE_INC && !tgt_virt && !tgt_ptr
        |=> mem.addr == $past(ptr[vpair]) + 12'h001 && mem.en)
        else $error("pre increment address wrong");

    a_pre_inc_step: assert property (
        vhit && vop == DAG_OP_PRE_INC && !ptr_wr
        |=> ptr[$past(vpair)] == $past(ptr[vpair]) + 12'h001)
        else $error("pre increment step wrong");

    // Carry and borrow must cross the byte boundary of the pair
    a_carry_step: assert property (
        vhit && vop == DAG_OP_POST_INC && !ptr_wr && ptr[vpair][7:0] == 8'hff
        |=> ptr[$past(vpair)][11:8] == 4'($past(ptr[vpair][11:8]) + 4'h1))
        else $error("increment carry lost");

    a_borrow_step: assert property (
        vhit && vop == DAG_OP_POST_DEC && !ptr_wr && ptr[vpair][7:0] == 8'h00
        |=> ptr[$past(vpair)][11:8] == 4'($past(ptr[vpair][11:8]) - 4'h1))
        else $error("decrement borrow lost");

    a_plain_hold: assert property (
        vhit && vop == DAG_OP_PLAIN && !ptr_wr && !apb_wr
        |=> ptr[$past(vpair)] == $past(ptr[vpair]))
        else $error("plain operand changed pointer");

    // Offset checked as a difference so it does not mirror the adder
    a_plus_wreg_addr: assert property (
        vhit && vop == DAG_OP_PLUS_WREG && !tgt_virt && !tgt_ptr && !apb_wr
        |=> 12'(mem.addr - $past(ptr[vpair])) == 12'($signed($past(req.wreg)))
            && ptr[$past(vpair)] == $past(ptr[vpair]))
        else $error("plus working address wrong");

    a_indirect_no_bank: assert property (
        vhit && vop == DAG_OP_PLAIN |=> resp.addr == $past(ptr[vpair]))
        else $error("indirect address used bank");

    a_null_read: assert property (
        dir_valid && tgt_virt |=> resp.null_access && resp.rdata == 8'h00 && !mem.en && !mem.we)
        else $error("virtual target not nulled");

    a_wreg_dest: assert property (
        dir_valid |=> resp.valid && resp.to_wreg == !$past(req.dest))
        else $error("destination select wrong");

    a_cfg_frozen: assert property (
        cfg_done |=> $stable(ext_cfg) && cfg_done)
        else $error("extended enable changed");

    a_access_low: assert property (
        req.valid && req.kind == DAG_FILE && !req.acc && !ext_cfg && req.file <= LIT_MAX
        |-> dir_addr[11:8] == ACCESS_LO_BANK)
        else $error("access low bank wrong");

    // Pointer bytes behave as real registers
    a_ptr_low_write: assert property (
        ptr_wr && top == DAG_OP_LOW |=> ptr[$past(tpair)][7:0] == $past(req.wdata))
        else $error("pointer low byte write wrong");

    a_ptr_high_write: assert property (
        ptr_wr && top == DAG_OP_HIGH |=> ptr[$past(tpair)][11:8] == $past(req.wdata[3:0]))
        else $error("pointer high byte write wrong");

    a_ptr_read: assert property (
        dir_valid && tgt_ptr && !tgt_virt && top == DAG_OP_LOW
        |=> resp.local_data && !mem.en && resp.rdata == $past(ptr[tpair][7:0]))
        else $error("pointer byte read wrong");

    a_high_nibble: assert property (
        dir_valid && tgt_ptr && top == DAG_OP_HIGH |=> resp.rdata[7:4] == 4'h0)
        else $error("pointer high nibble not zero");

    a_inherent_idle: assert property (
        req.valid && req.kind == DAG_NONE |=> !resp.valid && !mem.en)
        else $error("inherent request answered");

    a_mem_strobe: assert property (
        dir_valid && !tgt_virt && !tgt_ptr
        |=> mem.en && mem.addr == resp.addr && mem.we == $past(req.write))
        else $error("memory strobe wrong");

    a_cfg_capture: assert property (
        !cfg_done && cfg_cnt == CFG_SETTLE |=> cfg_done && ext_cfg == $past(ext_sync))
        else $error("extended enable not captured");

    c_post_inc: cover property (vhit && vop == DAG_OP_POST_INC);
    c_literal: cover property (req.valid && req.kind == DAG_FILE && !req.acc && ext_cfg
                               && req.file <= LIT_MAX);
    c_null: cover property (dir_valid && tgt_virt);
    c_ptr_write: cover property (ptr_wr && vhit);
    c_ptr_byte: cover property (dir_valid && tgt_ptr && !vhit);
endmodule : dag_core

`default_nettype wire

/* dv/dag_ram_model.sv */
// Behavioural data RAM standing behind the address generator's strobe.
// Assumes the registered memory strobe of dag_core on the same clock.
`default_nettype none

module dag_ram_model (
    input wire logic clk_sys,
    input wire dag_pkg::dag_mem_t mem,
    input wire logic [11:0] peek_addr,
    output logic [7:0] peek_data
);
    timeunit 1ns;
    timeprecision 1ns;
    import dag_pkg::*;
    logic [7:0] ram [0:4095];

    // Stores only on write strobes; unwritten cells stay unknown
    always_ff @(posedge clk_sys) begin
        if (mem.en && mem.we) begin
            ram[mem.addr] <= mem.wdata;
        end
    end

    // Bench-side look into the array
    assign peek_data = ram[peek_addr];
endmodule : dag_ram_model

`default_nettype wire

/* dv/data_address_generator_tb_top.sv */
// Self-checking bench for the data address generator: core requests and APB.
// Assumes dag_core, the RAM model and one 20 MHz clock.
`default_nettype none

module data_address_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dag_pkg::*;
    logic clk_sys;
    logic rst;
    logic ext_enable_pin;
    dag_req_t req;
    dag_mem_t mem;
    dag_resp_t resp;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] peek_addr;
    logic [7:0] peek_data;
    logic [7:0] cur_wreg;
    logic [7:0] cur_bank;
    logic cur_dest;
    int n_errors;
    int n_tests;
    int cycles;

    dag_core u_dag_core (.clk_sys(clk_sys), .rst(rst), .ext_enable_pin(ext_enable_pin),
        .req(req), .mem(mem), .resp(resp), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    dag_ram_model u_dag_ram_model (.clk_sys(clk_sys), .mem(mem), .peek_addr(peek_addr),
        .peek_data(peek_data));

    // Free-running clock, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // Hang guard, far above the roughly 130 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; waits on pready with no assumed latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask : wr_reg

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk("register", rd, exp);
    endtask : chk_reg

    // One core request; returns just after the answer edge has landed
    task automatic core_op(input dag_kind_t k, input logic acc, input logic [11:0] a,
                           input logic wr, input logic [7:0] wd);
        dag_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.kind = k;
        r.acc = acc;
        r.dest = cur_dest;
        r.write = wr;
        r.file = a[7:0];
        r.full = a;
        r.wdata = wd;
        r.wreg = cur_wreg;
        r.bank = cur_bank;
        @(posedge clk_sys);
        req <= r;
        @(posedge clk_sys);
        req <= '0;
        #1;
    endtask : core_op

    task automatic t_reset(input logic ext);
        logic [31:0] rd;
        logic er;
        @(posedge clk_sys);
        rst <= 1'b1;
        ext_enable_pin <= ext;
        repeat (6) @(posedge clk_sys);
        chk("ready in reset", pready, 1'b0);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        ext_enable_pin <= ~ext; // Late pin moves must not reach the mode
        chk_reg(REG_STATUS, {30'h0, 1'b1, ext});
        chk_reg(REG_POINTER2, 32'h0);
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk("unmapped error", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
    endtask : t_reset

    // Access through a pair 0 operand in the access bank, then pointer check
    task automatic step(input logic [7:0] f, input logic [11:0] ea, input logic [11:0] ep);
        core_op(DAG_FILE, 1'b0, {4'hf, f}, 1'b0, 8'h00);
        chk("step addr", resp.addr, ea);
        chk("step strobe", mem.en, 1'b1);
        chk_reg(REG_POINTER0, ep);
    endtask : step

    task automatic t_pointers;
        wr_reg(REG_POINTER1, 32'hffff_f0ff);
        chk_reg(REG_POINTER1, 32'h0ff);
        wr_reg(REG_POINTER0, 32'h0ff);
        cur_bank = 8'h05;
        step(8'hee, 12'h0ff, 12'h100);
        step(8'hed, 12'h100, 12'h0ff);
        step(8'hec, 12'h100, 12'h100);
        cur_wreg = 8'h80;
        step(8'heb, 12'h080, 12'h100);
        chk_reg(REG_POINTER1, 32'h0ff);
        step(8'hef, 12'h100, 12'h100);
        core_op(DAG_FULL, 1'b1, 12'hfef, 1'b1, 8'ha5);
        chk("full addr", resp.addr, 12'h100);
        chk("write strobe", mem.we, 1'b1);
        peek_addr <= 12'h100;
        repeat (2) @(posedge clk_sys);
        chk("ram data", peek_data, 8'ha5);
    endtask : t_pointers

    task automatic t_special;
        wr_reg(REG_POINTER0, 32'hfe7);
        core_op(DAG_FILE, 1'b0, 12'hfef, 1'b0, 8'h00);
        chk("null flag", resp.null_access, 1'b1);
        chk("null data", resp.rdata, 8'h00);
        core_op(DAG_FILE, 1'b0, 12'hfef, 1'b1, 8'h77);
        chk("null strobe", mem.en, 1'b0);
        chk("null write", mem.we, 1'b0);
        wr_reg(REG_POINTER2, 32'hfd9);
        core_op(DAG_FILE, 1'b0, 12'hfdd, 1'b1, 8'h34);
        chk_reg(REG_POINTER2, 32'hf34);
        core_op(DAG_FILE, 1'b0, 12'hfe9, 1'b1, 8'h5a);
        chk("local data", resp.local_data, 1'b1);
        chk_reg(REG_POINTER0, 32'hf5a);
        core_op(DAG_FILE, 1'b0, 12'hfea, 1'b0, 8'h00);
        chk("high byte", resp.rdata, 8'h0f);
        core_op(DAG_FILE, 1'b0, 12'hfea, 1'b1, 8'h3c);
        chk_reg(REG_POINTER0, 32'hc5a);
    endtask : t_special

    task automatic t_banked;
        cur_bank = 8'h13;
        cur_dest = 1'b0;
        core_op(DAG_FILE, 1'b1, 12'h042, 1'b0, 8'h00);
        chk("bank addr", resp.addr, 12'h342);
        chk("to wreg", resp.to_wreg, 1'b1);
        cur_dest = 1'b1;
        core_op(DAG_FILE, 1'b0, 12'h010, 1'b0, 8'h00);
        chk("access low", resp.addr, 12'h010);
        chk("to source", resp.to_wreg, 1'b0);
    endtask : t_banked

    task automatic t_extended;
        t_reset(1'b1);
        wr_reg(REG_POINTER2, 32'h200);
        core_op(DAG_FILE, 1'b0, 12'h05f, 1'b0, 8'h00);
        chk("indexed", resp.addr, 12'h25f);
        core_op(DAG_FILE, 1'b0, 12'h060, 1'b0, 8'h00);
        chk("forced", resp.addr, 12'hf60);
        cur_bank = 8'h02;
        core_op(DAG_FILE, 1'b1, 12'h010, 1'b0, 8'h00);
        chk("banked", resp.addr, 12'h210);
        wr_reg(REG_POINTER0, 32'h123);
        core_op(DAG_FILE, 1'b0, 12'hfef, 1'b0, 8'h00);
        chk("pair 0", resp.addr, 12'h123);
        core_op(DAG_NONE, 1'b0, 12'h010, 1'b0, 8'h00);
        chk("no answer", resp.valid, 1'b0);
        chk("no strobe", mem.en, 1'b0);
    endtask : t_extended

    // Main sequence; inputs start quiet with reset held
    initial begin
        rst = 1'b1;
        ext_enable_pin = 1'b0;
        req = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        peek_addr = 12'h000;
        cur_wreg = 8'h00;
        cur_bank = 8'h00;
        cur_dest = 1'b1;
        n_errors = 0;
        n_tests = 0;
        cycles = 0;
        t_reset(1'b0);
        t_pointers();
        t_special();
        t_banked();
        t_extended();
        final_report();
    end
endmodule : data_address_generator_tb_top

`default_nettype wire
